// ==== hw/sarc_conv_ctrl.sv ====
// Converter control: command and configuration registers, trigger arbitration, status and result.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sarc_conv_ctrl
  import sarc_pkg::*;
#(
  parameter int DATA_W = 32
)(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              soc_i,
  input  wire logic              cmp_i,
  output logic                   irq_o,
  output logic                   power_on_o,
  output logic                   clock_on_o,
  output logic      [1:0]        power_level_o,
  output logic      [11:0]       dac_code_o,
  output logic                   sampling_o,
  output logic                   busy_o
);

  if (DATA_W < 16) begin : g_bad_data
    $error("sarc_conv_ctrl needs a data path of at least 16 bits");
  end

  sarc_conv_if conv ();

  sarc_sar_engine #(
    .MAX_W (12)
  ) u_engine (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .conv     (conv.eng)
  );

  logic              pwr_ff;
  logic              clk_on_ff;
  logic [1:0]        lvl_ff;
  sarc_mode_t        mode_ff;
  logic              irq_en_ff;
  logic [3:0]        width_cfg_ff;
  logic              src_sw_ff;
  logic              running_ff;
  logic              sw_pend_ff;
  logic              hw_pend_ff;
  logic              soc_prev_ff;
  logic              start_ff;
  logic              abort_ff;
  logic              eoc_ff;
  logic              irq_ff;
  logic [11:0]       result_ff;
  logic [3:0]        run_w_ff;
  logic [3:0]        res_w_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              cmp_s1_ff;
  logic              cmp_s2_ff;
  logic              cmp_s3_ff;
  logic              cmp_ff;

  logic        cmd_wr;
  logic        cmd_start;
  logic        cmd_shut;
  logic        cmd_enable;
  logic        cmd_go;
  logic        cmd_halt;
  logic        cfg_wr;
  logic        stat_rd;
  logic        res_rd;
  logic        active;
  logic        soc_rise;
  logic        want;
  logic        launch;
  logic [15:0] signed_res;

  assign cmd_wr     = wr_i && (addr_i == ADDR_CMD);
  assign cmd_shut   = cmd_wr && wdata_i[CMD_SHUTDOWN_BIT];
  assign cmd_start  = cmd_wr && wdata_i[CMD_START_BIT] && !cmd_shut;
  assign cmd_enable = cmd_wr && wdata_i[CMD_ENABLE_BIT] && !cmd_shut;
  // Software start and stop are ignored while the external trigger owns conversions.
  assign cmd_go     = cmd_wr && wdata_i[CMD_GO_BIT] && (mode_ff != SARC_MODE_HW);
  assign cmd_halt   = cmd_wr && wdata_i[CMD_HALT_BIT] && (mode_ff != SARC_MODE_HW);
  assign cfg_wr     = wr_i && (addr_i == ADDR_CFG);
  assign stat_rd    = rd_i && (addr_i == ADDR_STAT);
  assign res_rd     = rd_i && ((addr_i == ADDR_RES16) || (addr_i == ADDR_RES8));
  assign active     = pwr_ff && clk_on_ff;
  assign signed_res = sarc_to_signed(result_ff, res_w_ff);

  // The comparator is an analogue pin; only a level seen by the last two stages counts.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      cmp_s3_ff <= 1'b0;
      cmp_ff    <= 1'b0;
    end
    else
    begin
      cmp_s1_ff <= cmp_i;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_s3_ff <= cmp_s2_ff;
      if (cmp_s2_ff == cmp_s3_ff)
        cmp_ff <= cmp_s3_ff;
    end
  end

  // Configuration register; illegal codes leave the field untouched.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_ff      <= CFG_MODE_RST;
      irq_en_ff    <= CFG_IRQ_RST;
      width_cfg_ff <= CFG_WIDTH_RST;
    end
    else if (cfg_wr)
    begin
      if (wdata_i[CFG_MODE_LSB +: 2] != 2'h3)
        mode_ff <= sarc_mode_t'(wdata_i[CFG_MODE_LSB +: 2]);
      irq_en_ff <= wdata_i[CFG_IRQ_BIT];
      if (sarc_width_ok(wdata_i[CFG_WIDTH_LSB +: 4]))
        width_cfg_ff <= wdata_i[CFG_WIDTH_LSB +: 4];
    end
  end

  // Power level sits apart because shutdown forces it to the lowest setting.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      lvl_ff <= CFG_PWR_RST;
    else if (cmd_shut)
      lvl_ff <= POWER_LEVEL_QUARTER;
    else if (cfg_wr && wdata_i[CFG_PWR_LSB +: 2] != POWER_LEVEL_RESERVED)
      lvl_ff <= wdata_i[CFG_PWR_LSB +: 2];
  end

  // Power and clock gates.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pwr_ff    <= 1'b0;
      clk_on_ff <= 1'b0;
    end
    else if (cmd_shut)
    begin
      pwr_ff    <= 1'b0;
      clk_on_ff <= 1'b0;
    end
    else if (cmd_start || cmd_enable)
    begin
      pwr_ff    <= 1'b1;
      clk_on_ff <= 1'b1;
    end
  end

  // Trigger source and pending requests.
  assign soc_rise = soc_i && !soc_prev_ff && !src_sw_ff && (mode_ff != SARC_MODE_FREE);
  assign want     = ((mode_ff == SARC_MODE_FREE) && running_ff && !cmd_halt)
                 || ((mode_ff == SARC_MODE_SW) && sw_pend_ff && !cmd_halt)
                 || ((mode_ff != SARC_MODE_FREE) && hw_pend_ff && !src_sw_ff);
  assign launch   = active && want && !conv.busy && !start_ff && !abort_ff;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      src_sw_ff   <= 1'b0;
      running_ff  <= 1'b0;
      sw_pend_ff  <= 1'b0;
      hw_pend_ff  <= 1'b0;
      soc_prev_ff <= 1'b0;
    end
    else if (cmd_shut || cmd_start)
    begin
      src_sw_ff   <= 1'b0;
      running_ff  <= 1'b0;
      sw_pend_ff  <= 1'b0;
      hw_pend_ff  <= 1'b0;
      soc_prev_ff <= soc_i;
    end
    else
    begin
      soc_prev_ff <= soc_i;
      if (cmd_halt)
      begin
        src_sw_ff  <= 1'b0;
        running_ff <= 1'b0;
        sw_pend_ff <= 1'b0;
      end
      else if (cmd_go)
      begin
        src_sw_ff  <= 1'b1;
        running_ff <= (mode_ff == SARC_MODE_FREE);
        sw_pend_ff <= (mode_ff == SARC_MODE_SW);
        hw_pend_ff <= 1'b0;
      end
      else if (launch)
        sw_pend_ff <= 1'b0;
      if (soc_rise && !cmd_go)
        hw_pend_ff <= 1'b1;
      else if (launch || src_sw_ff)
        hw_pend_ff <= 1'b0;
    end
  end

  // One-cycle launch and abort strobes; the width is taken at launch, not at the write.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      run_w_ff <= CFG_WIDTH_RST;
    end
    else
    begin
      start_ff <= launch && !cmd_shut && !cmd_start;
      abort_ff <= cmd_shut || cmd_start;
      if (launch)
        run_w_ff <= width_cfg_ff;
    end
  end

  assign conv.start = start_ff;
  assign conv.abort = abort_ff;
  assign conv.width = run_w_ff;
  assign conv.cmp   = cmp_ff;

  // Completion: result and status move on the same edge, and a new completion beats a clear.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      eoc_ff    <= 1'b0;
      result_ff <= 12'h000;
      res_w_ff  <= CFG_WIDTH_RST;
    end
    else if (conv.done)
    begin
      eoc_ff    <= 1'b1;
      result_ff <= conv.result;
      res_w_ff  <= run_w_ff;
    end
    else if (stat_rd || start_ff || cmd_start)
      eoc_ff <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_ff <= 1'b0;
    else if (cmd_start || cmd_shut)
      irq_ff <= 1'b0;
    else
      irq_ff <= irq_en_ff && (conv.done || (irq_ff && !res_rd));
  end

  // Read port: data stand only in the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_ff <= '0;
    else
    begin
      rdata_ff <= '0;
      if (rd_i)
      begin
        unique case (addr_i)
          ADDR_CFG:
          begin
            rdata_ff[CFG_PWR_LSB +: 2]   <= lvl_ff;
            rdata_ff[CFG_MODE_LSB +: 2]  <= mode_ff;
            rdata_ff[CFG_IRQ_BIT]        <= irq_en_ff;
            rdata_ff[CFG_WIDTH_LSB +: 4] <= width_cfg_ff;
          end
          ADDR_STAT:
          begin
            rdata_ff[STAT_EOC_BIT]     <= eoc_ff;
            rdata_ff[STAT_BUSY_BIT]    <= conv.busy;
            rdata_ff[STAT_POWERED_BIT] <= pwr_ff;
            rdata_ff[STAT_SRC_SW_BIT]  <= src_sw_ff;
            rdata_ff[STAT_RUNNING_BIT] <= running_ff;
          end
          ADDR_RES16: rdata_ff[15:0] <= signed_res;
          ADDR_RES8:  rdata_ff[7:0]  <= signed_res[7:0];
          default:    rdata_ff       <= '0;
        endcase
      end
    end
  end

  assign rdata_o       = rdata_ff;
  assign irq_o         = irq_ff;
  assign power_on_o    = pwr_ff;
  assign clock_on_o    = clk_on_ff;
  assign power_level_o = lvl_ff;
  assign dac_code_o    = conv.dac_code;
  assign sampling_o    = conv.sampling;
  assign busy_o        = conv.busy;

  property p_pwr_reserved;
    @(posedge clk_i) disable iff (!resetn_i)
    (cfg_wr && !cmd_shut && wdata_i[CFG_PWR_LSB +: 2] == POWER_LEVEL_RESERVED) |=> $stable(power_level_o);
  endproperty
  a_pwr_reserved: assert property (p_pwr_reserved) else $error("reserved power code was taken");

  property p_width_legal;
    @(posedge clk_i) disable iff (!resetn_i)
    sarc_width_ok(width_cfg_ff) && sarc_width_ok(run_w_ff);
  endproperty
  a_width_legal: assert property (p_width_legal) else $error("illegal result width held");

  property p_free_run;
    @(posedge clk_i) disable iff (!resetn_i)
    (mode_ff == SARC_MODE_FREE && running_ff && active && !cfg_wr && !cmd_wr && conv.done) |-> ##[1:3] start_ff;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not restart");

  property p_ext_blocked;
    @(posedge clk_i) disable iff (!resetn_i)
    (src_sw_ff && !hw_pend_ff) |=> !hw_pend_ff;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked) else $error("external trigger accepted after software start");

  property p_halt;
    @(posedge clk_i) disable iff (!resetn_i)
    (cmd_halt && mode_ff == SARC_MODE_FREE && !start_ff) |=> (!start_ff && !conv.abort) [*2];
  endproperty
  a_halt: assert property (p_halt) else $error("conversion launched or aborted after stop");

  property p_halt_sw;
    @(posedge clk_i) disable iff (!resetn_i)
    (cmd_halt && mode_ff == SARC_MODE_SW) |=> (!src_sw_ff && !sw_pend_ff);
  endproperty
  a_halt_sw: assert property (p_halt_sw) else $error("stop left software trigger selected");

  property p_irq_cause;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(irq_o) |-> ($past(conv.done) && $past(irq_en_ff));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled completion");

  property p_irq_clear;
    @(posedge clk_i) disable iff (!resetn_i)
    (res_rd && !conv.done) |=> !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("result read kept interrupt");

  property p_eoc_clear;
    @(posedge clk_i) disable iff (!resetn_i)
    (stat_rd && !conv.done) |=> !eoc_ff;
  endproperty
  a_eoc_clear: assert property (p_eoc_clear) else $error("status survived its read");

  property p_latch;
    @(posedge clk_i) disable iff (!resetn_i)
    (conv.done && !abort_ff) |=> (eoc_ff && result_ff == $past(conv.result));
  endproperty
  a_latch: assert property (p_latch) else $error("status and result not latched together");

  property p_start_cmd;
    @(posedge clk_i) disable iff (!resetn_i)
    cmd_start |=> (power_on_o && clock_on_o && !running_ff && !irq_o) ##1 !busy_o;
  endproperty
  a_start_cmd: assert property (p_start_cmd) else $error("start command did not reset control");

  property p_shut;
    @(posedge clk_i) disable iff (!resetn_i)
    cmd_shut |=> (!power_on_o && power_level_o == POWER_LEVEL_QUARTER) ##1 !busy_o;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown left converter active");

  property p_narrow;
    @(posedge clk_i) disable iff (!resetn_i)
    (rd_i && addr_i == ADDR_RES8) |=> (rdata_o[7:0] == $past(signed_res[7:0]) && rdata_o[15:8] == 8'h00);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow read is not the low byte");

endmodule

// ==== hw/sarc_sar_engine.sv ====
// Successive-approximation sequencer: settle phase, then one decision per result bit.
`timescale 1ns/1ps
module sarc_sar_engine
  import sarc_pkg::*;
#(
  parameter int MAX_W = 12
)(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  sarc_conv_if.eng  conv
);

  typedef enum logic [1:0] {ENG_IDLE, ENG_SETTLE, ENG_BITS} sarc_eng_state_t;

  if (MAX_W != 12) begin : g_bad_width
    $error("sarc_sar_engine serves a 12-bit result only");
  end

  sarc_eng_state_t state_ff;
  logic [3:0]      cnt_ff;
  logic [3:0]      width_ff;
  logic [3:0]      bit_ff;
  logic [11:0]     dac_ff;
  logic [11:0]     result_ff;
  logic            busy_ff;
  logic            done_ff;
  logic            sampling_ff;
  logic [11:0]     nxt_acc;
  logic [4:0]      len_ff;

  function automatic logic [11:0] bit_mask(input logic [3:0] i);
    return 12'h001 << i;
  endfunction

  // A rejected trial bit is cleared, an accepted one is kept.
  assign nxt_acc = conv.cmp ? dac_ff : (dac_ff & ~bit_mask(bit_ff));

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff    <= ENG_IDLE;
      cnt_ff      <= 4'h0;
      width_ff    <= WIDTH_TWELVE;
      bit_ff      <= 4'h0;
      dac_ff      <= 12'h000;
      result_ff   <= 12'h000;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      sampling_ff <= 1'b0;
    end
    else if (conv.abort)
    begin
      state_ff    <= ENG_IDLE;
      dac_ff      <= 12'h000;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      sampling_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      unique case (state_ff)
        ENG_IDLE:
        begin
          if (conv.start)
          begin
            width_ff    <= conv.width;
            cnt_ff      <= SETTLE_CYCLES - 4'h1;
            state_ff    <= ENG_SETTLE;
            busy_ff     <= 1'b1;
            sampling_ff <= 1'b1;
            dac_ff      <= 12'h000;
          end
        end
        ENG_SETTLE:
        begin
          if (cnt_ff == 4'h0)
          begin
            state_ff    <= ENG_BITS;
            sampling_ff <= 1'b0;
            bit_ff      <= width_ff - 4'h1;
            dac_ff      <= bit_mask(width_ff - 4'h1);
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        ENG_BITS:
        begin
          if (bit_ff == 4'h0)
          begin
            result_ff <= nxt_acc;
            done_ff   <= 1'b1;
            busy_ff   <= 1'b0;
            state_ff  <= ENG_IDLE;
          end
          else
          begin
            bit_ff <= bit_ff - 4'h1;
            dac_ff <= nxt_acc | bit_mask(bit_ff - 4'h1);
          end
        end
      endcase
    end
  end

  assign conv.busy     = busy_ff;
  assign conv.done     = done_ff;
  assign conv.result   = result_ff;
  assign conv.dac_code = dac_ff;
  assign conv.sampling = sampling_ff;

  // Cycle count since the accepted start, read only by the checks below.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      len_ff <= 5'h00;
    else if (state_ff == ENG_IDLE && conv.start)
      len_ff <= 5'h00;
    else if (busy_ff)
      len_ff <= len_ff + 5'h01;
  end

  property p_len;
    @(posedge clk_i) disable iff (!resetn_i)
    (done_ff && !$past(conv.abort)) |-> (len_ff == {1'b0, SETTLE_CYCLES} + {1'b0, width_ff});
  endproperty
  a_len: assert property (p_len) else $error("conversion length differs from settle plus width");

  property p_width_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    (busy_ff && $past(busy_ff)) |-> $stable(width_ff);
  endproperty
  a_width_hold: assert property (p_width_hold) else $error("width changed inside a conversion");

endmodule

// ==== include/sarc_conv_if.sv ====
// Signals between the control logic and the successive-approximation engine.
`timescale 1ns/1ps
interface sarc_conv_if;
  logic        start;
  logic        abort;
  logic [3:0]  width;
  logic        cmp;
  logic        busy;
  logic        done;
  logic [11:0] result;
  logic [11:0] dac_code;
  logic        sampling;
  modport ctrl (output start, abort, width, cmp, input busy, done, result, dac_code, sampling);
  modport eng  (input start, abort, width, cmp, output busy, done, result, dac_code, sampling);
endinterface

// ==== include/sarc_pkg.sv ====
// Shared constants, types and helpers of the converter control block.
// Behaviour
// - Power code 0 normal, 1 half, 3 quarter power; code 2 is reserved.
// - Result width is selectable as 12, 10 or 8, given as bit count.
// - A width written mid-conversion takes effect only after that conversion ends.
// - New-width data is valid six plus new-width cycles after the change.
// - Free-running mode converts back to back after one start command; here a software start begins it and the start command stops it.
// - Software-trigger mode needs one software start per conversion.
// - A software start stops the external trigger from starting conversions.
// - A stop lets the running conversion finish, then starts no more.
// - In software-trigger mode a stop hands the trigger back to the external input.
// - End-of-conversion interrupt is raised only while it is enabled.
// - Reading the result clears a pending interrupt.
// - Completion status reads nonzero when done, zero while converting, clears on read.
// - The narrow read at widths above 8 returns the result's low byte.
// - Results are read in two's complement form.
// - The start command powers up and returns control state to initial values.
// - The shutdown command halts conversions and enters lowest power.
// - The enable command switches on converter clock and power.
// - The wide read returns the full signed result for widths 8 to 12.
package sarc_pkg;

  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_CFG   = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [7:0] ADDR_RES16 = 8'h0c;
  localparam logic [7:0] ADDR_RES8  = 8'h10;

  localparam int CMD_START_BIT    = 0;
  localparam int CMD_SHUTDOWN_BIT = 1;
  localparam int CMD_ENABLE_BIT   = 2;
  localparam int CMD_GO_BIT       = 3;
  localparam int CMD_HALT_BIT     = 4;

  localparam int CFG_PWR_LSB   = 0;
  localparam int CFG_MODE_LSB  = 2;
  localparam int CFG_IRQ_BIT   = 4;
  localparam int CFG_WIDTH_LSB = 8;

  localparam int STAT_EOC_BIT     = 0;
  localparam int STAT_BUSY_BIT    = 1;
  localparam int STAT_POWERED_BIT = 2;
  localparam int STAT_SRC_SW_BIT  = 3;
  localparam int STAT_RUNNING_BIT = 4;

  localparam logic [1:0] POWER_LEVEL_NORMAL   = 2'h0;
  localparam logic [1:0] POWER_LEVEL_HALF     = 2'h1;
  localparam logic [1:0] POWER_LEVEL_RESERVED = 2'h2;
  localparam logic [1:0] POWER_LEVEL_QUARTER  = 2'h3;

  localparam logic [3:0] WIDTH_TWELVE = 4'hc;
  localparam logic [3:0] WIDTH_TEN    = 4'ha;
  localparam logic [3:0] WIDTH_EIGHT  = 4'h8;

  localparam logic [3:0] SETTLE_CYCLES = 4'h6;

  typedef enum logic [1:0] {SARC_MODE_FREE, SARC_MODE_SW, SARC_MODE_HW} sarc_mode_t;

  localparam logic [1:0] CFG_PWR_RST   = POWER_LEVEL_NORMAL;
  localparam sarc_mode_t CFG_MODE_RST  = SARC_MODE_SW;
  localparam logic       CFG_IRQ_RST   = 1'b0;
  localparam logic [3:0] CFG_WIDTH_RST = WIDTH_TWELVE;

  function automatic logic sarc_width_ok(input logic [3:0] w);
    return (w == WIDTH_TWELVE) || (w == WIDTH_TEN) || (w == WIDTH_EIGHT);
  endfunction

  // Raw counts are offset binary; flipping the top bit and extending it gives two's complement.
  function automatic logic [15:0] sarc_to_signed(input logic [11:0] raw, input logic [3:0] w);
    logic [15:0] v;
    logic        sgn;
    v   = {4'h0, raw};
    sgn = ~raw[w - 4'h1];
    for (int i = 0; i < 16; i++)
    begin
      if (i >= int'(w) - 1)
        v[i] = sgn;
    end
    return v;
  endfunction

endpackage

// ==== tb/sar_adc_conversion_control_test.sv ====
// Self-checking bench for the converter control block, driven over its register port.
`timescale 1ns/1ps
module sar_adc_conversion_control_test
  import sarc_pkg::*;
();
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        soc_i = 1'b0;
  logic        cmp_i = 1'b1;
  logic [31:0] rdata_o;
  logic        irq_o, power_on_o, clock_on_o, sampling_o, busy_o, prev_busy;
  logic [1:0]  power_level_o;
  logic [11:0] dac_code_o;
  logic [3:0]  wt [3] = '{4'hc, 4'ha, 4'h8};
  logic [1:0]  pw [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0]  pe [4] = '{2'h1, 2'h3, 2'h3, 2'h0};
  int          num_errors = 0, total_checks = 0, cyc = 0, cnt = 0, last_len = 0, nconv = 0, n0, k;
  int          scnt = 0, last_samp = 0;

  sarc_conv_ctrl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .soc_i(soc_i), .cmp_i(cmp_i), .irq_o(irq_o), .power_on_o(power_on_o),
    .clock_on_o(clock_on_o), .power_level_o(power_level_o), .dac_code_o(dac_code_o),
    .sampling_o(sampling_o), .busy_o(busy_o));

  always #4 clk_i = ~clk_i;

  // Busy-run length and launch count are watched here so that no scenario can miss a short run.
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    prev_busy <= busy_o;
    if (busy_o === 1'b1)
      cnt <= cnt + 1;
    else
    begin
      if (cnt != 0)
        last_len <= cnt;
      cnt <= 0;
    end
    if (busy_o === 1'b1 && prev_busy !== 1'b1)
      nconv <= nconv + 1;
    if (sampling_o === 1'b1)
      scnt <= scnt + 1;
    else
    begin
      if (scnt != 0)
        last_samp <= scnt;
      scnt <= 0;
    end
    if (cyc == 6000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task print_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] ex);
    total_checks++;
    if (got !== ex)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o & m, ex);
  endtask

  task wait_idle();
    for (k = 0; k < 100 && busy_o !== 1'b0; k++)
    begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
  endtask

  task pulse_soc();
    @(posedge clk_i);
    soc_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    soc_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] p, input logic [1:0] m, input logic q, input logic [3:0] w);
    return {20'h0, w, 3'h0, q, m, p};
  endfunction

  // A held comparator level makes every trial decision alike, so the raw count is all ones or all zeros.
  function automatic logic [31:0] res(input logic c, input logic [3:0] w, input logic wide);
    logic [31:0] msk;
    logic [31:0] v;
    msk = (32'h1 << w) - 32'h1;
    v = (c ? msk : 32'h0) ^ (32'h1 << (w - 4'h1));
    if (v[w - 4'h1])
      v = v | ~msk;
    return wide ? {16'h0, v[15:0]} : {24'h0, v[7:0]};
  endfunction

  initial
  begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    chk({31'h0, power_on_o}, 32'h0);
    wr(ADDR_CMD, 32'h1 << CMD_SHUTDOWN_BIT);
    chk({29'h0, power_on_o, power_level_o}, 32'h3);
    wr(ADDR_CMD, 32'h1 << CMD_ENABLE_BIT);
    chk({30'h0, power_on_o, clock_on_o}, 32'h3);
    wr(ADDR_CMD, 32'h1 << CMD_START_BIT);
    rchk(ADDR_STAT, 32'h1f, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CFG, cfg(pw[i], 2'h1, 1'b0, 4'hc));
      chk({30'h0, power_level_o}, {30'h0, pe[i]});
    end
    wr(ADDR_CFG, cfg(2'h0, 2'h3, 1'b0, 4'h9));
    rchk(ADDR_CFG, 32'hfff, cfg(2'h0, 2'h1, 1'b0, 4'hc));
    rchk(8'h14, 32'hffffffff, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i) cmp_i <= (i != 1);
      wr(ADDR_CFG, cfg(2'h0, 2'h1, 1'b1, wt[i]));
      wr(ADDR_CMD, 32'h1 << CMD_GO_BIT);
      rchk(ADDR_STAT, 32'h1, 32'h0);
      wait_idle();
      chk(last_len, 32'h6 + wt[i]);
      chk(last_samp, 32'h6);
      chk({20'h0, dac_code_o}, (i != 1) ? (32'h1 << wt[i]) - 32'h1 : 32'h1);
      chk({31'h0, irq_o}, 32'h1);
      rchk(ADDR_STAT, 32'h1, 32'h1);
      rchk(ADDR_STAT, 32'h1, 32'h0);
      rchk(ADDR_RES8, 32'hffffffff, res(i != 1, wt[i], 1'b0));
      chk({31'h0, irq_o}, 32'h0);
      rchk(ADDR_RES16, 32'hffffffff, res(i != 1, wt[i], 1'b1));
    end
    wr(ADDR_CFG, cfg(2'h0, 2'h1, 1'b0, 4'hc));
    wr(ADDR_CMD, 32'h1 << CMD_GO_BIT);
    wr(ADDR_CFG, cfg(2'h0, 2'h1, 1'b0, 4'h8));
    wait_idle();
    chk(last_len, 32'h12);
    chk({31'h0, irq_o}, 32'h0);
    wr(ADDR_CMD, 32'h1 << CMD_GO_BIT);
    rchk(ADDR_STAT, 32'h8, 32'h8);
    wait_idle();
    chk(last_len, 32'he);
    n0 = nconv;
    pulse_soc();
    chk(nconv, n0);
    wr(ADDR_CMD, 32'h1 << CMD_HALT_BIT);
    rchk(ADDR_STAT, 32'h8, 32'h0);
    pulse_soc();
    chk(nconv, n0 + 1);
    wait_idle();
    wr(ADDR_CFG, cfg(2'h0, 2'h2, 1'b0, 4'h8));
    pulse_soc();
    chk(nconv, n0 + 2);
    wait_idle();
    wr(ADDR_CFG, cfg(2'h0, 2'h0, 1'b0, 4'h8));
    n0 = nconv;
    wr(ADDR_CMD, 32'h1 << CMD_GO_BIT);
    repeat (60) @(posedge clk_i);
    #1;
    chk({31'h0, (nconv - n0) >= 3}, 32'h1);
    for (k = 0; k < 40 && busy_o !== 1'b1; k++)
      #8;
    wr(ADDR_CMD, 32'h1 << CMD_HALT_BIT);
    wait_idle();
    chk(last_len, 32'he);
    n0 = nconv;
    repeat (40) @(posedge clk_i);
    chk(nconv, n0);
    // A shutdown right behind a launch must abort the running conversion.
    wr(ADDR_CMD, 32'h1 << CMD_START_BIT);
    wr(ADDR_CMD, 32'h1 << CMD_GO_BIT);
    wr(ADDR_CMD, 32'h1 << CMD_SHUTDOWN_BIT);
    repeat (2) @(posedge clk_i);
    #1;
    chk({30'h0, busy_o, power_on_o}, 32'h0);
    print_verdict();
  end
endmodule
